// ### hdl/emcs_ctrl.sv
// How it works
// (R1) four-bit addr_mode_sel picks memory type, address lines and chip selects
// (R2) three-bit word_len_sel picks 8/16/24, 16+24addr, 12 or 20 bit words
// (R3) bus_width_sel: 0 gives 4-bit data bus, 1 gives 8-bit bus
// (R4) incr_after_read set bumps base_address_reg after each read
// (R5) incr_after_write set bumps base_address_reg after each write
// (R6) irq_source_sel: off, write-empty, read-full, buffer-and-read-full
// (R7) wrap interrupt enabled while its control bit is clear
// (R8) read_trigger_sel: 0 offset write starts read, 1 data read starts read
// (R9) read_reg_full reads 1 while read_data_reg holds a word
// (R10) write_reg_empty reads 1 while write_data_reg is empty
// (R11) buffer_and_read_full reads 1 when buffer and read register both full
// (R12) transfer_pending reads 1 while transfers or requests pend
// (R13) SRAM word takes multiplier times (4 plus sram_wait_field) clocks
// (R14) absolute DRAM word takes N*12 or N*8 clocks by dram_timing_sel
// (R15) iface_enable clear holds the interface in individual reset
// (R16) memory answers on selected bus width within programmed clocks
// (R17) writes to read-only status flags have no effect
`timescale 1ns/1ps
`default_nettype none
module emcs_ctrl
	import emcs_pkg::*;
(
	// clock and reset
	input  wire logic               i_clk,
	input  wire logic               i_rstn,
	// wishbone slave
	input  wire logic               i_wb_cyc,
	input  wire logic               i_wb_stb,
	input  wire logic               i_wb_we,
	input  wire logic [7:0]         i_wb_adr,
	input  wire logic [3:0]         i_wb_sel,
	input  wire logic [31:0]        i_wb_dat,
	output logic [31:0]             o_wb_dat,
	output logic                    o_wb_ack,
	// memory side
	output logic [3:0]              o_mem_chip_select,
	output logic [15:0]             o_mem_address_lines,
	output logic                    o_mem_ras,
	output logic                    o_mem_cas,
	output logic                    o_mem_rd,
	output logic                    o_mem_wr,
	output logic [23:0]             o_mem_wdata,
	output emcs_pkg::emcs_fmt_type  o_fmt,
	// interrupt
	output logic                    o_irq
);
	import emcs_pkg::*;
	typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR} emcs_state_type;

	// ---------------------------------------------
	// bus decode
	// ---------------------------------------------
	logic        req;
	logic        wr_acc;
	logic        rd_acc;
	logic [31:0] wmask;
	logic [31:0] wval;
	assign req    = i_wb_cyc & i_wb_stb & ~o_wb_ack;
	assign wr_acc = req & i_wb_we;
	assign rd_acc = req & ~i_wb_we;
	assign wmask  = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

	logic [23:0] csr_r;
	logic [15:0] base_r;
	logic [15:0] roff_r;
	logic [23:0] rdata_r;
	logic [23:0] wdata_r;
	logic [23:0] buf_r;
	logic        rfull_r;
	logic        bfull_r;
	logic        wfull_r;
	logic        rpend_r;
	logic [2:0]  irq_st_r;
	logic [2:0]  irq_msk_r;
	logic [23:0] memdin_r;
	logic [7:0]  cnt_r;
	emcs_state_type state_r;

	logic [3:0] am;
	logic [2:0] wl;
	logic       bw;
	logic       en;
	assign am = csr_r[F_AM_LO +: 4];
	assign wl = {csr_r[F_WL2], csr_r[F_WL_LO +: 2]};
	assign bw = csr_r[F_BW];
	assign en = csr_r[F_EME];
	assign o_fmt = '{addr_mode_sel: am, word_len_sel: wl, bus_width_sel: bw};

	// ---------------------------------------------
	// word timing
	// ---------------------------------------------
	logic [7:0] bits_w;
	logic [7:0] n_acc;
	logic [7:0] word_clks;
	always_comb begin
		// (R2) word length decode
		case (wl)
			3'h0: bits_w = 8'd8;
			3'h1: bits_w = 8'd16;
			3'h2: bits_w = 8'd24;
			3'h3: bits_w = 8'd16;
			3'h5: bits_w = 8'd12;
			3'h6: bits_w = 8'd20;
			default: bits_w = 8'd8;
		endcase
		// (R3) accesses per word by bus width
		if (bw)
			n_acc = (bits_w + 8'd7) >> 3;
		else
			n_acc = bits_w >> 2;
		// (R13) sram timing
		if (am < AM_DRAM_LO)
			word_clks = 8'(n_acc * (SRAM_BASE + {4'h0, csr_r[F_STM_LO +: 4]}));
		// (R14) absolute dram timing
		else if (am >= AM_DRAM_ABS)
			word_clks = 8'(n_acc * (csr_r[F_DTM] ? DRAM_SLOW : DRAM_FAST));
		else
			word_clks = 8'(n_acc * DRAM_REL);
	end

	// ---------------------------------------------
	// address and strobes
	// ---------------------------------------------
	logic [15:0] eff_addr;
	logic        busy;
	assign busy     = (state_r != ST_IDLE);
	assign eff_addr = 16'(base_r + (state_r == ST_RD ? roff_r : 16'h0000));
	always_comb begin
		// (R1) chip select and address lines by mode
		o_mem_chip_select   = 4'h0;
		o_mem_address_lines = eff_addr;
		o_mem_ras           = 1'b0;
		o_mem_cas           = 1'b0;
		if (busy) begin
			case (am)
				AM_SRAM_ABS: o_mem_address_lines = {1'b0, eff_addr[14:0]};
				4'h1: o_mem_chip_select = 4'h1;
				4'h2: o_mem_chip_select = 4'h3;
				4'h3: o_mem_chip_select = 4'hF;
				default: begin
					o_mem_ras = 1'b1;
					o_mem_cas = cnt_r[0];
				end
			endcase
		end
	end
	assign o_mem_rd    = (state_r == ST_RD);
	assign o_mem_wr    = (state_r == ST_WR);
	assign o_mem_wdata = wdata_r;

	// ---------------------------------------------
	// transfer engine
	// ---------------------------------------------
	logic rd_trig;
	logic rd_data_rd;
	logic wdata_wr;
	logic done;
	logic wrap;
	assign rd_data_rd = rd_acc & (i_wb_adr == ADDR_RDATA);
	assign wdata_wr   = wr_acc & (i_wb_adr == ADDR_WDATA) & en;
	// (R8) read trigger source
	assign rd_trig    = en & (csr_r[F_RTS] ? rd_data_rd
		: (wr_acc & (i_wb_adr == ADDR_ROFF)));
	assign done       = busy & (cnt_r == 8'h01);
	assign wrap       = done & (base_r == BASE_ADDR_MAX) &
		((state_r == ST_RD & csr_r[F_INR]) | (state_r == ST_WR & csr_r[F_INW]));

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_r <= ST_IDLE;
			cnt_r   <= 8'h00;
		// (R15) individual reset
		end else if (!en) begin
			state_r <= ST_IDLE;
			cnt_r   <= 8'h00;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (rpend_r & ~bfull_r) begin
						state_r <= ST_RD;
						cnt_r   <= word_clks;
					end else if (wfull_r) begin
						state_r <= ST_WR;
						cnt_r   <= word_clks;
					end
				end
				ST_RD, ST_WR: begin
					cnt_r <= 8'(cnt_r - 8'h01);
					if (done)
						state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// base address, offset, pending read
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			base_r  <= 16'h0000;
			roff_r  <= 16'h0000;
			rpend_r <= 1'b0;
		end else begin
			if (wr_acc & (i_wb_adr == ADDR_BASE))
				base_r <= i_wb_dat[15:0];
			// (R4) increment after read
			else if (done & (state_r == ST_RD) & csr_r[F_INR])
				base_r <= 16'(base_r + 16'h0001);
			// (R5) increment after write
			else if (done & (state_r == ST_WR) & csr_r[F_INW])
				base_r <= 16'(base_r + 16'h0001);
			if (wr_acc & (i_wb_adr == ADDR_ROFF))
				roff_r <= i_wb_dat[15:0];
			if (!en)
				rpend_r <= 1'b0;
			else if (rd_trig)
				rpend_r <= 1'b1;
			else if (state_r == ST_IDLE & ~bfull_r)
				rpend_r <= 1'b0;
		end
	end

	// read data path: read register first, buffer while read register is full
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			buf_r   <= 24'h000000;
			bfull_r <= 1'b0;
			rdata_r <= 24'h000000;
			rfull_r <= 1'b0;
		end else if (!en) begin
			bfull_r <= 1'b0;
			rfull_r <= 1'b0;
		end else begin
			if (done & (state_r == ST_RD)) begin
				if (!rfull_r | rd_data_rd) begin
					rdata_r <= memdin_r;
					rfull_r <= 1'b1;
				end else begin
					buf_r   <= memdin_r;
					bfull_r <= 1'b1;
				end
			end else if (rd_data_rd) begin
				// (R9) read register drains from buffer
				rdata_r <= buf_r;
				rfull_r <= bfull_r;
				bfull_r <= 1'b0;
			end
		end
	end

	// write data register
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wdata_r <= 24'h000000;
			wfull_r <= 1'b0;
		end else if (!en) begin
			wfull_r <= 1'b0;
		end else if (wdata_wr) begin
			wdata_r <= i_wb_dat[23:0];
			wfull_r <= 1'b1;
		// (R10) emptied when transfer starts
		end else if (state_r == ST_IDLE & wfull_r & ~(rpend_r & ~bfull_r)) begin
			wfull_r <= 1'b0;
		end
	end

	// ---------------------------------------------
	// registers
	// ---------------------------------------------
	logic [23:0] status_bits;
	always_comb begin
		status_bits          = 24'h000000;
		// (R9) read full flag
		status_bits[F_DRF]   = rfull_r;
		// (R10) write empty flag
		status_bits[F_DWE]   = ~wfull_r;
		// (R11) buffer and read full
		status_bits[F_BDF]   = bfull_r & rfull_r;
		// (R12) busy flag
		status_bits[F_BSY]   = busy | wfull_r | rpend_r;
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			csr_r    <= CSR_RESET & ~CSR_RO_MASK;
			memdin_r <= 24'h000000;
		end else begin
			// (R17) status flags not writable
			if (wr_acc & (i_wb_adr == ADDR_CSR))
				csr_r <= ((csr_r & ~wmask[23:0]) | (i_wb_dat[23:0] & wmask[23:0]))
					& ~CSR_RO_MASK;
			if (wr_acc & (i_wb_adr == ADDR_MEMDIN))
				memdin_r <= i_wb_dat[23:0];
		end
	end

	// ---------------------------------------------
	// interrupts
	// ---------------------------------------------
	logic [2:0] ev;
	always_comb begin
		ev = 3'h0;
		// (R6) source select
		case (csr_r[F_IS_LO +: 2])
			IS_WRITE: ev[IRQ_WR] = ~wfull_r;
			IS_READ:  ev[IRQ_RD] = rfull_r;
			IS_BUFRD: ev[IRQ_RD] = bfull_r & rfull_r;
			default:  ev[IRQ_RD] = 1'b0;
		endcase
		// (R7) wrap enabled when clear
		ev[IRQ_WRAP] = wrap & ~csr_r[F_WRAP];
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			irq_st_r  <= 3'h0;
			irq_msk_r <= 3'h0;
		end else begin
			if (wr_acc & (i_wb_adr == ADDR_IRQ_ST))
				irq_st_r <= (irq_st_r & ~i_wb_dat[2:0]) | ev;
			else
				irq_st_r <= irq_st_r | ev;
			if (wr_acc & (i_wb_adr == ADDR_IRQ_MSK))
				irq_msk_r <= i_wb_dat[2:0];
		end
	end
	assign o_irq = |(irq_st_r & irq_msk_r);

	// read mux and ack
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h00000000;
		end else begin
			o_wb_ack <= req;
			if (rd_acc) begin
				case (i_wb_adr)
					ADDR_CSR:     o_wb_dat <= {8'h00, csr_r | status_bits};
					ADDR_BASE:    o_wb_dat <= {16'h0000, base_r};
					ADDR_ROFF:    o_wb_dat <= {16'h0000, roff_r};
					ADDR_RDATA:   o_wb_dat <= {8'h00, rdata_r};
					ADDR_IRQ_ST:  o_wb_dat <= {29'h0, irq_st_r};
					ADDR_IRQ_MSK: o_wb_dat <= {29'h0, irq_msk_r};
					ADDR_MEMDIN:  o_wb_dat <= {8'h00, memdin_r};
					ADDR_TIMING:  o_wb_dat <= {24'h000000, word_clks};
					default:      o_wb_dat <= 32'h00000000;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ### hdl/emcs_pkg.sv
package emcs_pkg;
	// ---------------------------------------------
	// register map (word offsets, bytes)
	// ---------------------------------------------
	localparam logic [7:0] ADDR_CSR     = 8'h00;
	localparam logic [7:0] ADDR_BASE    = 8'h04;
	localparam logic [7:0] ADDR_ROFF    = 8'h08;
	localparam logic [7:0] ADDR_RDATA   = 8'h0C;
	localparam logic [7:0] ADDR_WDATA   = 8'h10;
	localparam logic [7:0] ADDR_IRQ_ST  = 8'h14;
	localparam logic [7:0] ADDR_IRQ_MSK = 8'h18;
	localparam logic [7:0] ADDR_MEMDIN  = 8'h1C;
	localparam logic [7:0] ADDR_TIMING  = 8'h20;
	// ---------------------------------------------
	// control/status word fields
	// ---------------------------------------------
	localparam logic [23:0] CSR_RESET   = 24'h7C0000;
	localparam int F_BW      = 0;
	localparam int F_WL_LO   = 1;
	localparam int F_AM_LO   = 3;
	localparam int F_INR     = 7;
	localparam int F_INW     = 8;
	localparam int F_IS_LO   = 9;
	localparam int F_WRAP    = 11;
	localparam int F_RTS     = 12;
	localparam int F_DRF     = 13;
	localparam int F_DWE     = 14;
	localparam int F_BDF     = 15;
	localparam int F_BSY     = 16;
	localparam int F_WL2     = 17;
	localparam int F_DTM     = 18;
	localparam int F_STM_LO  = 19;
	localparam int F_EME     = 23;
	localparam logic [23:0] CSR_RO_MASK = 24'h01E000;
	// ---------------------------------------------
	// codes and timing
	// ---------------------------------------------
	localparam logic [3:0] AM_SRAM_ABS = 4'h0;
	localparam logic [3:0] AM_DRAM_LO  = 4'h4;
	localparam logic [3:0] AM_DRAM_ABS = 4'hC;
	localparam logic [1:0] IS_OFF      = 2'h0;
	localparam logic [1:0] IS_WRITE    = 2'h1;
	localparam logic [1:0] IS_READ     = 2'h2;
	localparam logic [1:0] IS_BUFRD    = 2'h3;
	localparam logic [7:0] SRAM_BASE   = 8'h04;
	localparam logic [7:0] DRAM_SLOW   = 8'h0C;
	localparam logic [7:0] DRAM_FAST   = 8'h08;
	localparam logic [7:0] DRAM_REL    = 8'h0C;
	localparam logic [15:0] BASE_ADDR_MAX = 16'hFFFF;
	// irq status bits
	localparam int IRQ_WR    = 0;
	localparam int IRQ_RD    = 1;
	localparam int IRQ_WRAP  = 2;
	typedef struct packed {
		logic [3:0] addr_mode_sel;
		logic [2:0] word_len_sel;
		logic       bus_width_sel;
	} emcs_fmt_type;
endpackage

// ### test/emcs_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module emcs_ctrl_bench;
	import emcs_pkg::*;
	logic         i_clk = 1'b0, i_rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0]   adr = 8'h00;
	logic [31:0]  dat = 32'h0, q, rs = 32'h42, v, e;
	logic [31:0]  o_dat;
	logic [15:0]  base, ma;
	logic [23:0]  wd, wr_seen;
	logic [3:0]   cs, stm;
	logic         ack, irq, mrd, mwr, ras, cas;
	emcs_fmt_type fmt;
	int           n_fail = 0, cmp_count = 0, n, rd_len, rd_cnt, wr_cnt;
	always #2 i_clk = ~i_clk;
	emcs_ctrl u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(dat), .o_wb_dat(o_dat),
		.o_wb_ack(ack), .o_mem_chip_select(cs), .o_mem_address_lines(ma), .o_mem_ras(ras),
		.o_mem_cas(cas), .o_mem_rd(mrd), .o_mem_wr(mwr), .o_mem_wdata(wd), .o_fmt(fmt),
		.o_irq(irq));
	emcs_mem_model u_mem (.i_clk(i_clk), .i_rd(mrd), .i_wr(mwr), .i_wdata(wd),
		.o_rd_len(rd_len), .o_rd_cnt(rd_cnt), .o_wr_cnt(wr_cnt), .o_wdata(wr_seen));
	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	function automatic logic [31:0] csr(logic [3:0] am, logic [2:0] wl, logic bw, logic inr,
		logic inw, logic [1:0] is, logic dtm, logic [3:0] st, logic en);
		return {8'h00, en, st, dtm, wl[2], 4'h0, 2'b00, is, inw, inr, am, wl[1:0], bw};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge i_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		@(posedge i_clk);
		while (ack !== 1'b1 && t < 50) begin
			t++;
			@(posedge i_clk);
		end
		if (ack !== 1'b1)
			n_fail++;
		q = o_dat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wait_cnt(ref int c, input int old);
		for (int t = 0; t < 400 && c == old; t++)
			@(posedge i_clk);
		if (c == old)
			n_fail++;
	endtask
	task automatic test_done();
		if (n_fail == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge i_clk);
		n_fail++;
		test_done();
	end
	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		repeat (6) @(posedge i_clk);
		i_rstn <= 1'b1;
		wb(0, ADDR_CSR, 0); chk(q, 32'h7C4000);
		wb(1, ADDR_CSR, 32'h01E000); wb(0, ADDR_CSR, 0); chk(q, 32'h004000);
		wb(1, 8'hFC, 32'hFFFFFF); wb(0, 8'hFC, 0); chk(q, 0);
		base = {1'b0, rnd() >> 17};
		wb(1, ADDR_BASE, {16'h0, base}); wb(1, ADDR_IRQ_MSK, 32'h2);
		for (int k = 0; k < 4; k++) begin
			stm = rnd() | 4'h4;
			v = csr(k == 3 ? AM_DRAM_ABS : AM_SRAM_ABS, k == 2 ? 3'h2 : 3'h0, k != 0, 1, 0,
				IS_READ, rs[20], stm, 1);
			e = k == 3 ? (rs[20] ? 12 : 8) : (k == 2 ? 3 : (k == 1 ? 1 : 2)) * (4 + stm);
			wb(1, ADDR_CSR, v); wb(0, ADDR_TIMING, 0); chk(q, e);
			v = rnd() & 32'hFFFFFF;
			wb(1, ADDR_MEMDIN, v); n = rd_cnt; wb(1, ADDR_ROFF, 0);
			wb(0, ADDR_CSR, 0); chk(q[F_BSY], 1);
			wait_cnt(rd_cnt, n); chk(rd_len, e);
			wb(0, ADDR_CSR, 0); chk(q[F_DRF], 1);
			chk(irq, 1);
			wb(0, ADDR_RDATA, 0);
			if (k == 2) chk(q, v);
			wb(1, ADDR_IRQ_ST, 32'h2); wb(0, ADDR_CSR, 0); chk(q[F_DRF], 0);
			chk(irq, 0);
		end
		wb(0, ADDR_BASE, 0); chk(q, base + 16'h4);
		wb(1, ADDR_CSR, csr(AM_SRAM_ABS, 3'h2, 1, 0, 1, IS_WRITE, 0, 4'h0, 1));
		wb(1, ADDR_IRQ_MSK, 32'h1);
		v = rnd() & 32'hFFFFFF; n = wr_cnt; wb(1, ADDR_WDATA, v);
		wait_cnt(wr_cnt, n); chk(wr_seen, v);
		wb(0, ADDR_BASE, 0); chk(q, base + 16'h5);
		wb(0, ADDR_CSR, 0); chk(q[F_DWE], 1);
		chk(irq, 1);
		wb(1, ADDR_IRQ_MSK, 0); wb(0, ADDR_CSR, 0); chk(irq, 0);
		wb(1, ADDR_BASE, 32'hFFFF);
		wb(1, ADDR_CSR, csr(AM_SRAM_ABS, 3'h0, 1, 1, 0, IS_BUFRD, 0, 4'h0, 1));
		wb(1, ADDR_IRQ_ST, 32'h7); wb(1, ADDR_IRQ_MSK, 32'h2);
		n = rd_cnt; wb(1, ADDR_ROFF, 0); wait_cnt(rd_cnt, n); chk(rd_len, 4);
		wb(0, ADDR_CSR, 0); chk(q[F_BDF], 0);
		chk(irq, 0);
		n = rd_cnt; wb(1, ADDR_ROFF, 0); wait_cnt(rd_cnt, n);
		wb(0, ADDR_CSR, 0); chk(q[F_BDF], 1);
		chk(irq, 1);
		wb(0, ADDR_IRQ_ST, 0); chk(q[IRQ_WRAP], 1);
		wb(0, ADDR_BASE, 0); chk(q, 32'h1);
		wb(0, ADDR_RDATA, 0); wb(0, ADDR_CSR, 0); chk(q[F_BDF], 0);
		chk(q[F_DRF], 1);
		wb(1, ADDR_CSR, csr(AM_SRAM_ABS, 3'h0, 0, 1, 0, IS_OFF, 0, 4'h0, 0));
		n = rd_cnt; wb(1, ADDR_ROFF, 0); wb(0, ADDR_CSR, 0); chk(q[F_BSY], 0);
		repeat (20) @(posedge i_clk);
		chk(rd_cnt, n);
		test_done();
	end
endmodule
`default_nettype wire

// ### test/emcs_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module emcs_ctrl_checker
	import emcs_pkg::*;
(
	// bus
	input  wire logic                   i_clk,
	input  wire logic                   i_rstn,
	input  wire logic                   i_wb_cyc,
	input  wire logic                   i_wb_stb,
	input  wire logic                   i_wb_we,
	input  wire logic [7:0]             i_wb_adr,
	input  wire logic [3:0]             i_wb_sel,
	input  wire logic [31:0]            i_wb_dat,
	input  wire logic [31:0]            o_wb_dat,
	input  wire logic                   o_wb_ack,
	// memory
	input  wire logic [3:0]             o_mem_chip_select,
	input  wire logic [15:0]            o_mem_address_lines,
	input  wire logic                   o_mem_ras,
	input  wire logic                   o_mem_cas,
	input  wire logic                   o_mem_rd,
	input  wire logic                   o_mem_wr,
	input  wire emcs_pkg::emcs_fmt_type o_fmt
);
	logic en_r;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			en_r <= 1'b0;
		else if (o_wb_ack && i_wb_we && i_wb_adr == ADDR_CSR && i_wb_sel[2])
			en_r <= i_wb_dat[F_EME];
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	sequence s_req; i_wb_cyc && i_wb_stb && !o_wb_ack; endsequence
	sequence s_csr_wr; o_wb_ack && i_wb_we && i_wb_adr == ADDR_CSR && i_wb_sel == 4'hF; endsequence
	a_ack_next_cycle: assert property (s_req |=> o_wb_ack) else $error("ack missing");
	a_ack_one_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
	a_fmt_follows_csr: assert property (s_csr_wr |=> o_fmt == {$past(i_wb_dat[6:3]),
		$past(i_wb_dat[17]), $past(i_wb_dat[2:0])}) else $error("format mismatch");
	a_abs_no_select: assert property (o_fmt.addr_mode_sel == AM_SRAM_ABS
		|-> o_mem_chip_select == 4'h0) else $error("select in absolute sram");
	a_sram_no_strobe: assert property (o_fmt.addr_mode_sel < AM_DRAM_LO
		|-> !o_mem_ras && !o_mem_cas) else $error("strobe in sram mode");
	a_rd_wr_apart: assert property (!(o_mem_rd && o_mem_wr)) else $error("read and write");
	a_abs_addr_narrow: assert property (o_fmt.addr_mode_sel == AM_SRAM_ABS
		&& (o_mem_rd || o_mem_wr) |-> !o_mem_address_lines[15])
		else $error("address line above absolute range");
	a_off_no_xfer: assert property (!en_r |-> !o_mem_rd && !o_mem_wr)
		else $error("transfer while disabled");
	a_hole_reads_zero: assert property (o_wb_ack && !i_wb_we && i_wb_adr > ADDR_TIMING
		|-> o_wb_dat == 32'h0) else $error("unmapped read not zero");
	a_upper_byte_zero: assert property (o_wb_ack && !i_wb_we |-> o_wb_dat[31:24] == 8'h00)
		else $error("upper byte set");
endmodule
bind emcs_ctrl emcs_ctrl_checker u_chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_wb_cyc(i_wb_cyc),
	.i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
	.i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
	.o_mem_chip_select(o_mem_chip_select), .o_mem_address_lines(o_mem_address_lines),
	.o_mem_ras(o_mem_ras), .o_mem_cas(o_mem_cas),
	.o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_fmt(o_fmt));
`default_nettype wire

// ### test/emcs_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module emcs_mem_model (
	input  wire logic        i_clk,
	input  wire logic        i_rd,
	input  wire logic        i_wr,
	input  wire logic [23:0] i_wdata,
	output int               o_rd_len,
	output int               o_rd_cnt,
	output int               o_wr_cnt,
	output logic [23:0]      o_wdata
);
	int   run_r = 0;
	logic wr_q  = 1'b0;
	initial begin
		o_rd_len = 0;
		o_rd_cnt = 0;
		o_wr_cnt = 0;
	end
	always @(posedge i_clk) begin
		wr_q <= i_wr;
		if (i_wr)
			o_wdata <= i_wdata;
		if (wr_q && !i_wr)
			o_wr_cnt <= o_wr_cnt + 1;
		if (i_rd)
			run_r <= run_r + 1;
		else if (run_r != 0) begin
			o_rd_len <= run_r;
			o_rd_cnt <= o_rd_cnt + 1;
			run_r <= 0;
		end
	end
endmodule
`default_nettype wire
